// ### bench/rnsf_exec_assertions.sv
// Handshake checks on the register port of the rotate / set-file datapath
module rnsf_exec_assertions (
   input wire logic core_clk, // Clock
   input wire logic rst, // Reset
   input wire logic awvalid, // Write address valid
   input wire logic awready, // Write address ready
   input wire logic wvalid, // Write data valid
   input wire logic wready, // Write data ready
   input wire logic [1:0] bresp, // Write response
   input wire logic bvalid, // Write response valid
   input wire logic bready, // Write response ready
   input wire logic arvalid, // Read address valid
   input wire logic arready, // Read address ready
   input wire logic [31:0] rdata, // Read data
   input wire logic [1:0] rresp, // Read response
   input wire logic rvalid, // Read data valid
   input wire logic rready // Read data ready
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // Answer one cycle after the request is taken
   AST_B_AFTER_W: assert property (awvalid && awready && wvalid && wready |=> bvalid)
      else $error("write response late");
   AST_R_AFTER_AR: assert property (arvalid && arready |=> rvalid) else $error("read response late");
   // Answers stand until taken
   AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response lost");
   AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read response changed");
   AST_B_DROP: assert property (bvalid && bready |=> !bvalid) else $error("write response repeated");
   AST_R_DROP: assert property (rvalid && rready |=> !rvalid) else $error("read response repeated");
   // No new request while an answer is pending; write answers are OKAY or SLVERR
   AST_AW_BLOCK: assert property (bvalid |-> !awready && !wready) else $error("write taken while busy");
   AST_AR_BLOCK: assert property (rvalid |-> !arready) else $error("read taken while busy");
   AST_RESP_OK: assert property (bvalid |-> bresp == 2'b00 || bresp == 2'b10) else $error("bad write response");
   // Main scenarios
   cover property (bvalid && bready && bresp == 2'b00);
   cover property (bvalid && bready && bresp == 2'b10);
   cover property (rvalid && rready);
endmodule
bind rnsf_exec rnsf_exec_assertions chk (.core_clk(core_clk), .rst(rst), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
   .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

// ### bench/test_rotate_nocarry_setfile_exec.sv
// Self-checking bench for the rotate / set-file datapath
`include "rnsf_map.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module test_rotate_nocarry_setfile_exec;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [11:0] awaddr = 0, araddr = 0; // Request addresses
   logic [31:0] wdata = 0; // Write data
   logic [3:0] wstrb = 0; // Byte strobes
   logic awready, wready, bvalid, arready, rvalid; // Handshake outputs
   logic [1:0] bresp, rresp, rs; // Responses
   logic [31:0] rdata, rdV; // Read data
   int n_fail = 0, tests_run = 0, cyc = 0;
   always #25 core_clk = ~core_clk;
   rnsf_exec uut (.core_clk(core_clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));
   task stop_test;
      if (n_fail == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Handshakes judged at the falling edge, acted on after the rising edge
   task wr(input [11:0] a, input [31:0] d, output [1:0] r);
      logic ah, wh, bh;
      @(posedge core_clk);
      awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(negedge core_clk);
         ah = awvalid && awready; wh = wvalid && wready; bh = bvalid; r = bresp;
         @(posedge core_clk);
         if (ah) awvalid <= 0;
         if (wh) wvalid <= 0;
      end while (!bh);
      bready <= 0;
   endtask
   task rd(input [11:0] a, output [31:0] d, output [1:0] r);
      logic ah, rh;
      @(posedge core_clk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin
         @(negedge core_clk);
         ah = arvalid && arready; rh = rvalid; d = rdata; r = rresp;
         @(posedge core_clk);
         if (ah) arvalid <= 0;
      end while (!rh);
      rready <= 0;
   endtask
   // Loads a byte, runs one instruction, checks file byte, working register and flags
   task run_op(input [7:0] ctl, input [15:0] opc, input [11:0] ph, input [7:0] pre, exF, exW, exS);
      wr(`RNSF_OFF_CTRL, {24'h0, ctl}, rs);
      wr(`RNSF_OFF_FADDR, {20'h0, ph}, rs);
      wr(`RNSF_OFF_FDATA, {24'h0, pre}, rs);
      wr(`RNSF_OFF_INSTR, {16'h0, opc}, rs);
      `CHK(rs, 2'b00)
      rd(`RNSF_OFF_FDATA, rdV, rs);
      `CHK(rdV, {24'h0, exF})
      rd(`RNSF_OFF_WREG, rdV, rs);
      `CHK(rdV, {24'h0, exW})
      rd(`RNSF_OFF_STATUS, rdV, rs);
      `CHK(rdV & 32'h14, {24'h0, exS})
      `CHK(rs, 2'b00)
   endtask
   task t_rotate;
      run_op(8'h30, 16'h4725, 12'h325, 8'hab, 8'h57, 8'h00, 8'h00);
      run_op(8'h30, 16'h4025, 12'h025, 8'hd7, 8'hd7, 8'heb, 8'h10);
      run_op(8'h30, 16'h4280, 12'hf80, 8'h01, 8'h80, 8'heb, 8'h10);
      run_op(8'h30, 16'h4410, 12'h010, 8'h00, 8'h00, 8'h00, 8'h04);
   endtask
   task t_set_all;
      run_op(8'h30, 16'h6944, 12'h344, 8'h5a, 8'hff, 8'h00, 8'h04);
   endtask
   // Indexed offsets up to the limit, plain access bank just above it
   task t_index;
      wr(`RNSF_OFF_INDEX, 32'h200, rs);
      run_op(8'h31, 16'h685f, 12'h25f, 8'h00, 8'hff, 8'h00, 8'h04);
      run_op(8'h31, 16'h4260, 12'hf60, 8'h02, 8'h01, 8'h00, 8'h00);
   endtask
   task t_unmapped;
      wr(12'h01c, 32'h1, rs);
      `CHK(rs, 2'b10)
      rd(12'h01c, rdV, rs);
      `CHK(rs, 2'b10)
      `CHK(rdV, 32'h0)
   endtask
   // Answers must stand while the master is slow to accept them
   task t_late_accept;
      @(posedge core_clk);
      awaddr <= `RNSF_OFF_WREG; wdata <= 32'h5c; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1;
      @(posedge core_clk);
      awvalid <= 0; wvalid <= 0;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      `CHK({bvalid, bresp}, 3'b100)
      @(posedge core_clk);
      bready <= 1;
      @(posedge core_clk);
      bready <= 0;
      rd(`RNSF_OFF_WREG, rdV, rs);
      `CHK(rdV, 32'h5c)
      @(posedge core_clk);
      araddr <= `RNSF_OFF_WREG; arvalid <= 1;
      @(posedge core_clk);
      arvalid <= 0;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      `CHK({rvalid, rresp, rdata}, {3'b100, 32'h5c})
      @(posedge core_clk);
      rready <= 1;
      @(posedge core_clk);
      rready <= 0;
   endtask
   // Cuts a hang short
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         stop_test();
      end
   end
   initial begin
      repeat (6) @(posedge core_clk);
      rst <= 0;
      t_rotate();
      t_set_all();
      t_index();
      t_unmapped();
      t_late_accept();
      stop_test();
   end
endmodule

// ### common/rnsf_map.svh
// Constants for the rotate / set-file execution datapath and its register window
`ifndef RNSF_MAP_SVH
`define RNSF_MAP_SVH
// -------------------------------------------------------------
// Register byte offsets
// -------------------------------------------------------------
`define RNSF_OFF_INSTR 12'h000
`define RNSF_OFF_CTRL 12'h004
`define RNSF_OFF_WREG 12'h008
`define RNSF_OFF_STATUS 12'h00c
`define RNSF_OFF_FADDR 12'h010
`define RNSF_OFF_FDATA 12'h014
`define RNSF_OFF_INDEX 12'h018
// -------------------------------------------------------------
// Fields, encodings and reset values
// -------------------------------------------------------------
`define RNSF_OPC_RRNC 6'h10
`define RNSF_OPC_RLNC 6'h11
`define RNSF_OPC_SETALL 7'h34
`define RNSF_IDX_LIMIT 8'h5f
`define RNSF_ALL_ONES 8'hff
`define RNSF_ACCESS_SPLIT 8'h60
`define RNSF_ACCESS_HI_BANK 4'hf
`define RNSF_CTRL_EXT_BIT 0
`define RNSF_CTRL_BANK_LSB 4
`define RNSF_FLAG_Z_BIT 2
`define RNSF_FLAG_N_BIT 4
`define RNSF_RST_BYTE 8'h00
`define RNSF_FILE_WORDS 4096
`endif

// ### common/rnsf_pkg.sv
// Types for the rotate / set-file execution datapath
package rnsf_pkg;
   // Decoded instruction kind
   typedef enum logic [1:0] {
      RNSF_NONE = 2'b00,
      RNSF_RLNC = 2'b01,
      RNSF_RRNC = 2'b10,
      RNSF_SETALL = 2'b11
   } rnsf_op_t;
   // Decoded operand fields of one instruction word
   typedef struct packed {
      rnsf_op_t op;
      logic dest;
      logic bankAccess;
      logic [7:0] fileAddr;
   } rnsf_dec_t;
endpackage

// ### rtl/rnsf_exec.sv
// Rotate-no-carry and set-file execution datapath with AXI4-Lite register window
// Functional notes
// RQ1: Rotate right: bit0 to bit7, update N,Z
// RQ2: Destination clear: result to working register only
// RQ3: Destination set: result written back to file
// RQ4: Access bit clear: access bank, ignore bank select
// RQ5: Access bit set: bank select picks bank
// RQ6: Extended set, access clear, f<=95: indexed
// RQ7: Set-file loads FFh, flags untouched
// RQ8: Set-file banking follows the access bit
// RQ9: Rotate left: bit7 to bit0, one cycle
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`include "rnsf_map.svh"
module rnsf_exec (
   input wire logic core_clk, // Instruction clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic [11:0] awaddr, // Write address
   input wire logic awvalid, // Write address valid
   output logic awready, // Write address ready
   input wire logic [31:0] wdata, // Write data
   input wire logic [3:0] wstrb, // Write byte strobes
   input wire logic wvalid, // Write data valid
   output logic wready, // Write data ready
   output logic [1:0] bresp, // Write response
   output logic bvalid, // Write response valid
   input wire logic bready, // Write response ready
   input wire logic [11:0] araddr, // Read address
   input wire logic arvalid, // Read address valid
   output logic arready, // Read address ready
   output logic [31:0] rdata, // Read data
   output logic [1:0] rresp, // Read response
   output logic rvalid, // Read data valid
   input wire logic rready // Read data ready
);
   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   logic [7:0] fileMem [0:`RNSF_FILE_WORDS-1]; // Data memory, 16 banks of 256
   logic [7:0] workReg; // Working register
   logic flagN; // Negative flag
   logic flagZ; // Zero flag
   logic extEnable; // Extended instruction set enabled
   logic [3:0] bank_select_register; // Bank select
   logic [11:0] indexBase; // Base pointer for indexed literal offset
   logic [11:0] peekAddr; // Debug window address into data memory
   logic awHeld, wHeld; // Captured write channels
   logic [11:0] awAddrQ; // Captured write address
   logic [31:0] wDataQ; // Captured write data
   logic [3:0] wStrbQ; // Captured strobes
   // -------------------------------------------------------------
   // Decode and execute (combinational)
   // -------------------------------------------------------------
   logic doWrite; // Both write channels present
   logic instrWrite; // Instruction word issued
   rnsf_pkg::rnsf_dec_t dec; // Decoded fields
   logic [11:0] effAddr; // Resolved data address
   logic [7:0] operand; // Byte read from file
   logic [7:0] next_result; // Computed byte
   logic [11:0] idxSum; // Indexed address sum
   assign doWrite = (awHeld | awvalid) & (wHeld | wvalid) & ~bvalid;
   logic [11:0] wrAddr; // Effective write address
   logic [31:0] wrData; // Effective write data
   logic [3:0] wrStrb; // Effective strobes
   assign wrAddr = awHeld ? awAddrQ : awaddr;
   assign wrData = wHeld ? wDataQ : wdata;
   assign wrStrb = wHeld ? wStrbQ : wstrb;
   assign instrWrite = doWrite && wrAddr == `RNSF_OFF_INSTR && wrStrb[1:0] == 2'h3;
   assign idxSum = indexBase + {4'h0, dec.fileAddr};
   // Decode the 16-bit opcode word
   always_comb begin
      dec.dest = wrData[9];
      dec.bankAccess = wrData[8];
      dec.fileAddr = wrData[7:0];
      if (wrData[15:10] == `RNSF_OPC_RRNC) begin
         dec.op = rnsf_pkg::RNSF_RRNC;
      end else if (wrData[15:10] == `RNSF_OPC_RLNC) begin
         dec.op = rnsf_pkg::RNSF_RLNC;
      end else if (wrData[15:9] == `RNSF_OPC_SETALL) begin
         dec.op = rnsf_pkg::RNSF_SETALL;
         dec.dest = 1'b1;
      end else begin
         dec.op = rnsf_pkg::RNSF_NONE;
      end
   end
   // Resolve the data address from the access bit, bank select and mode
   always_comb begin
      if (!dec.bankAccess && extEnable && dec.fileAddr <= `RNSF_IDX_LIMIT) begin
         effAddr = idxSum; // [RQ6]
      end else if (!dec.bankAccess) begin
         // Access bank: low part in bank 0, high part in the top bank [RQ4] [RQ8]
         effAddr = (dec.fileAddr < `RNSF_ACCESS_SPLIT) ? {4'h0, dec.fileAddr}
                                                       : {`RNSF_ACCESS_HI_BANK, dec.fileAddr};
      end else begin
         effAddr = {bank_select_register, dec.fileAddr}; // [RQ5] [RQ8]
      end
   end
   assign operand = fileMem[effAddr];
   // Compute the result byte
   always_comb begin
      case (dec.op)
         rnsf_pkg::RNSF_RLNC: next_result = {operand[6:0], operand[7]}; // [RQ9]
         rnsf_pkg::RNSF_RRNC: next_result = {operand[0], operand[7:1]}; // [RQ1]
         rnsf_pkg::RNSF_SETALL: next_result = `RNSF_ALL_ONES; // [RQ7]
         default: next_result = operand;
      endcase
   end
   // -------------------------------------------------------------
   // Data memory and working register update
   // -------------------------------------------------------------
   // File write-back, completes in the cycle the word is issued
   always_ff @(posedge core_clk) begin
      if (instrWrite && dec.op != rnsf_pkg::RNSF_NONE && dec.dest) begin
         fileMem[effAddr] <= next_result; // [RQ3] [RQ7]
      end else if (doWrite && wrAddr == `RNSF_OFF_FDATA && wrStrb[0]) begin
         fileMem[peekAddr] <= wrData[7:0];
      end
   end
   // Working register, written by instructions with the destination bit clear and by register writes to its offset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         workReg <= `RNSF_RST_BYTE;
      end else if (instrWrite && dec.op != rnsf_pkg::RNSF_NONE && !dec.dest) begin
         workReg <= next_result; // [RQ2]
      end else if (doWrite && wrAddr == `RNSF_OFF_WREG && wrStrb[0]) begin
         workReg <= wrData[7:0];
      end
   end
   // Negative and zero flags, touched by rotates and by register writes to the status offset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         flagN <= 1'b0;
         flagZ <= 1'b0;
      end else if (instrWrite && (dec.op == rnsf_pkg::RNSF_RLNC || dec.op == rnsf_pkg::RNSF_RRNC)) begin
         flagN <= next_result[7]; // [RQ1] [RQ9]
         flagZ <= (next_result == 8'h00); // [RQ1] [RQ9]
      end else if (doWrite && wrAddr == `RNSF_OFF_STATUS && wrStrb[0]) begin
         flagN <= wrData[`RNSF_FLAG_N_BIT];
         flagZ <= wrData[`RNSF_FLAG_Z_BIT];
      end
   end
   // Control, index and peek registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         extEnable <= 1'b0;
         bank_select_register <= 4'h0;
         indexBase <= 12'h000;
         peekAddr <= 12'h000;
      end else if (doWrite) begin
         if (wrAddr == `RNSF_OFF_CTRL && wrStrb[0]) begin
            extEnable <= wrData[`RNSF_CTRL_EXT_BIT];
            bank_select_register <= wrData[`RNSF_CTRL_BANK_LSB +: 4];
         end
         if (wrAddr == `RNSF_OFF_INDEX && wrStrb[1:0] == 2'h3) begin
            indexBase <= wrData[11:0];
         end
         if (wrAddr == `RNSF_OFF_FADDR && wrStrb[1:0] == 2'h3) begin
            peekAddr <= wrData[11:0];
         end
      end
   end
   // -------------------------------------------------------------
   // AXI4-Lite write channels
   // -------------------------------------------------------------
   assign awready = ~awHeld & ~bvalid;
   assign wready = ~wHeld & ~bvalid;
   // Hold whichever channel arrives first until the other one comes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddrQ <= 12'h000;
         wDataQ <= 32'h0000_0000;
         wStrbQ <= 4'h0;
      end else if (doWrite) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
      end else begin
         if (awvalid && awready) begin
            awHeld <= 1'b1;
            awAddrQ <= awaddr;
         end
         if (wvalid && wready) begin
            wHeld <= 1'b1;
            wDataQ <= wdata;
            wStrbQ <= wstrb;
         end
      end
   end
   // Write response, unmapped offsets answer SLVERR
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bvalid <= 1'b0;
         bresp <= 2'b00;
      end else if (doWrite) begin
         bvalid <= 1'b1;
         bresp <= (wrAddr <= `RNSF_OFF_INDEX && wrAddr[1:0] == 2'b00) ? 2'b00 : 2'b10;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end
   // -------------------------------------------------------------
   // AXI4-Lite read channel
   // -------------------------------------------------------------
   assign arready = ~rvalid;
   // Read mux, data registered
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= 2'b00;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rresp <= 2'b00;
         case (araddr)
            `RNSF_OFF_INSTR: rdata <= 32'h0000_0000;
            `RNSF_OFF_CTRL: rdata <= {24'h0, bank_select_register, 3'h0, extEnable};
            `RNSF_OFF_WREG: rdata <= {24'h0, workReg};
            `RNSF_OFF_STATUS: rdata <= {27'h0, flagN, 1'b0, flagZ, 2'h0};
            `RNSF_OFF_FADDR: rdata <= {20'h0, peekAddr};
            `RNSF_OFF_FDATA: rdata <= {24'h0, fileMem[peekAddr]};
            `RNSF_OFF_INDEX: rdata <= {20'h0, indexBase};
            default: begin
               rdata <= 32'h0000_0000;
               rresp <= 2'b10;
            end
         endcase
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end
endmodule
